//--- design/buck_fault_monitor.sv
// Fault and power-good supervisor for a synchronous buck controller, APB slave.
// Assumes soft_start_done comes from pclk logic; comparators and enable are async.
// Contract
// RL1 - Output below undervoltage threshold latches off with both gates low.
// RL2 - Undervoltage latch clears only on power-on reset, not enable toggle.
// RL3 - Undervoltage protection armed only after soft-start completes.
// RL4 - Build option removes undervoltage protection; power-good window stays.
// RL5 - Overvoltage latches off; upper low, lower high until below half nominal.
// RL6 - Overvoltage latch clears only on power-on reset.
// RL7 - Overvoltage protection armed from reset release, active during soft-start.
// RL8 - Overcurrent never blocks overvoltage; first overcurrent blocks undervoltage latch.
// RL9 - Power-good high only inside the narrow window comparators.
// RL10 - Power-good held low from reset and through soft-start.
// RL11 - Power-good may rise immediately once soft-start is done.
// RL12 - Overcurrent drives power-good low directly.
// RL13 - Protection latches have no direct path to power-good.
// RL14 - Overcurrent power-good low cleared by reset, enable toggle, or good soft-start.
// RL15 - Hiccup variant waits about 10 ms then restarts soft-start, forever.
// RL16 - Switching frequency fixed per variant; timings identical at either.
// RL17 - Upper-gate duty capped at 85 or 75 percent by variant.
// RL18 - Power-good is open drain: drives low, releases when good.
// RL19 - Asynchronous comparators and enable are synchronised before use.
//
// Decided for this implementation: the APB register port and the address map.
module buck_fault_monitor
  import fault_mon_pkg::*;
#(
  parameter bit UV_PROT_EN    = 1'b1,
  parameter bit HICCUP_MODE   = 1'b0,
  parameter bit FAST_VARIANT  = 1'b0,
  parameter int HICCUP_CYCLES = HICCUP_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        uv_prot_raw,
  input  wire logic        ov_prot_raw,
  input  wire logic        below_half_raw,
  input  wire logic        pg_uv_raw,
  input  wire logic        pg_ov_raw,
  input  wire logic        overcurrent_trip_raw,
  input  wire logic        enable_raw,
  input  wire logic        soft_start_done,
  output logic             upper_gate_drive,
  output logic             lower_gate_drive,
  output logic             power_good_output,
  output logic             power_good_oe,
  output logic             soft_start_restart,
  output logic             irq
);

  // ****************************************
  // Variant selection
  // ****************************************
  localparam int PERIOD   = FAST_VARIANT ? PERIOD_FAST : PERIOD_SLOW;
  localparam int DMAX_PCT = FAST_VARIANT ? DMAX_FAST_PCT : DMAX_SLOW_PCT;
  localparam int MAX_ON   = (PERIOD * DMAX_PCT) / 100;
  localparam int HW       = $clog2(HICCUP_CYCLES + 1);
  localparam logic [HW-1:0] HLAST = HW'(HICCUP_CYCLES - 1);

  // ****************************************
  // Input synchronisers
  // ****************************************
  sync_bus_if sb ();

  input_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (clk_en),
    .raw     ({enable_raw, overcurrent_trip_raw, pg_ov_raw, pg_uv_raw,
                below_half_raw, ov_prot_raw, uv_prot_raw}), // RL19
    .sb      (sb.src)
  );

  // ****************************************
  // State
  // ****************************************
  logic             ctrl_run_q;
  logic [7:0]       duty_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic             uv_latch_q;
  logic             ov_latch_q;
  logic             oc_block_q;
  logic             oc_off_q;
  logic             pg_oc_low_q;
  logic             lower_hi_q;
  logic             en_q;
  logic             oc_q;
  logic             ss_q;
  logic             pg_q;
  logic [HW-1:0]    hic_cnt_q;

  logic             pwm_on;
  logic             en_eff;
  logic             uv_set;
  logic             ov_set;
  logic             oc_rise;
  logic             ss_rise;
  logic             en_fall;
  logic             hic_done;
  logic             pg_d;
  logic             upper_d;
  logic             lower_d;
  logic             lower_hi_d;
  logic [IRQ_W-1:0] events;

  assign en_eff   = sb.enable && ctrl_run_q;
  assign oc_rise  = sb.oc_trip && !oc_q;
  assign ss_rise  = soft_start_done && !ss_q;
  assign en_fall  = !sb.enable && en_q;
  assign hic_done = HICCUP_MODE && oc_off_q && (hic_cnt_q == HLAST);

  // ****************************************
  // Protection latches
  // ****************************************
  assign uv_set = UV_PROT_EN && soft_start_done && sb.uv_prot
                  && !oc_block_q && !uv_latch_q; // RL3 RL4 RL8
  assign ov_set = sb.ov_prot && !ov_latch_q; // RL7 RL8

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_latch_q <= 1'b0;
      ov_latch_q <= 1'b0;
    end else if (clk_en) begin
      if (uv_set) begin
        uv_latch_q <= 1'b1; // RL1 RL2
      end
      if (ov_set) begin
        ov_latch_q <= 1'b1; // RL6
      end
    end
  end

  // Lower gate pulls the output down until it passes below half nominal
  assign lower_hi_d = sb.ov_prot ? 1'b1 : (sb.below_half ? 1'b0 : lower_hi_q); // RL5

  // ****************************************
  // Overcurrent handling and hiccup retry
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oc_block_q  <= 1'b0;
      oc_off_q    <= 1'b0;
      pg_oc_low_q <= 1'b0;
      hic_cnt_q   <= '0;
      en_q        <= 1'b0;
      oc_q        <= 1'b0;
      ss_q        <= 1'b0;
      lower_hi_q  <= 1'b0;
    end else if (clk_en) begin
      en_q       <= sb.enable;
      oc_q       <= sb.oc_trip;
      ss_q       <= soft_start_done;
      lower_hi_q <= lower_hi_d;
      if (sb.oc_trip && !uv_latch_q) begin
        oc_block_q <= 1'b1; // RL8
      end else if (en_fall) begin
        oc_block_q <= 1'b0;
      end
      if (oc_rise) begin
        oc_off_q <= 1'b1;
      end else if (hic_done || (!HICCUP_MODE && en_fall)) begin
        oc_off_q <= 1'b0; // RL15
      end
      if (sb.oc_trip) begin
        pg_oc_low_q <= 1'b1; // RL12
      end else if (en_fall || ss_rise) begin
        pg_oc_low_q <= 1'b0; // RL14
      end
      if (oc_off_q && HICCUP_MODE && !hic_done) begin
        hic_cnt_q <= HW'(hic_cnt_q + 1'b1); // RL15
      end else begin
        hic_cnt_q <= '0;
      end
    end
  end

  // ****************************************
  // Modulator with duty cap
  // ****************************************
  duty_limiter #(
    .PERIOD (PERIOD),
    .MAX_ON (MAX_ON)
  ) u_pwm (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (clk_en),
    .run     (en_eff && !oc_off_q && !uv_latch_q && !ov_latch_q),
    .duty    (duty_q),
    .pwm_on  (pwm_on)
  ); // RL16 RL17

  // ****************************************
  // Gate commands and power-good
  // ****************************************
  assign upper_d = pwm_on && en_eff && !uv_latch_q && !ov_latch_q && !oc_off_q; // RL1 RL5
  assign lower_d = ov_latch_q ? lower_hi_d
                 : (en_eff && !uv_latch_q && !oc_off_q && !pwm_on); // RL1 RL5
  // Besides soft-start done and enable, only window comparators and overcurrent reach power-good
  assign pg_d    = soft_start_done && en_eff && !sb.pg_uv && !sb.pg_ov
                   && !pg_oc_low_q && !sb.oc_trip; // RL9 RL10 RL11 RL12 RL13

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_gate_drive   <= 1'b0;
      lower_gate_drive   <= 1'b0;
      pg_q               <= 1'b0;
      power_good_output  <= 1'b0;
      power_good_oe      <= 1'b1;
      soft_start_restart <= 1'b0;
    end else if (clk_en) begin
      upper_gate_drive   <= upper_d;
      lower_gate_drive   <= lower_d;
      pg_q               <= pg_d;
      power_good_output  <= 1'b0;
      power_good_oe      <= !pg_d; // RL18
      soft_start_restart <= hic_done; // RL15
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign events[IRQ_UV]    = uv_set;
  assign events[IRQ_OV]    = ov_set;
  assign events[IRQ_OC]    = oc_rise;
  assign events[IRQ_PGF]   = pg_q && !pg_d;
  assign events[IRQ_RETRY] = hic_done;

  // ****************************************
  // APB slave, no wait states
  // ****************************************
  logic        acc;
  logic        wr;
  logic        hit_ctrl;
  logic        hit_duty;
  logic        hit_stat;
  logic        hit_istat;
  logic        hit_imask;
  logic        mapped;
  logic [31:0] rdata_d;
  logic [7:0]  status;

  assign acc       = psel && penable && pready;
  assign wr        = acc && pwrite;
  assign hit_ctrl  = (paddr == OFF_CTRL);
  assign hit_duty  = (paddr == OFF_DUTY);
  assign hit_stat  = (paddr == OFF_STATUS);
  assign hit_istat = (paddr == OFF_IRQ_STAT);
  assign hit_imask = (paddr == OFF_IRQ_MASK);
  assign mapped    = hit_ctrl || hit_duty || hit_stat || hit_istat || hit_imask;
  assign status    = {sb.enable, soft_start_done, lower_hi_q, pg_q,
                      pg_oc_low_q, oc_off_q, ov_latch_q, uv_latch_q};
  assign rdata_d   = hit_ctrl  ? {31'h0, ctrl_run_q}
                   : hit_duty  ? {24'h0, duty_q}
                   : hit_stat  ? {24'h0, status}
                   : hit_istat ? {27'h0, irq_stat_q}
                   : hit_imask ? {27'h0, irq_mask_q}
                   : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (clk_en) begin
      pready  <= psel && !penable && !pready;
      pslverr <= psel && !penable && !pready && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rdata_d : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_run_q <= CTRL_RST;
      duty_q     <= DUTY_RST;
      irq_mask_q <= IRQ_RST;
      irq_stat_q <= IRQ_RST;
      irq        <= 1'b0;
    end else if (clk_en) begin
      if (wr && hit_ctrl) begin
        ctrl_run_q <= pwdata[0];
      end
      if (wr && hit_duty) begin
        duty_q <= pwdata[7:0];
      end
      if (wr && hit_imask) begin
        irq_mask_q <= pwdata[IRQ_W-1:0];
      end
      // A new event wins over a write-one clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~((wr && hit_istat) ? pwdata[IRQ_W-1:0] : IRQ_RST))
                    | events;
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk iff clk_en);
  endclocking
  default disable iff (!presetn);

  sequence s_ov_trip;
    ov_latch_q && sb.ov_prot;
  endsequence
  sequence s_drop_half;
    !sb.ov_prot && sb.below_half;
  endsequence

  a_uv_gates_off:  assert property (uv_latch_q && !ov_latch_q |=>
                     !upper_gate_drive && !lower_gate_drive)
                     else $error("gates active after undervoltage latch"); // RL1
  a_uv_latch_keep: assert property (uv_latch_q |=> uv_latch_q [*8])
                     else $error("undervoltage latch cleared"); // RL2
  a_uv_armed_ss:   assert property ($rose(uv_latch_q) |-> $past(soft_start_done))
                     else $error("undervoltage latched during soft-start"); // RL3
  a_uv_option_off: assert property (!UV_PROT_EN |-> !uv_latch_q)
                     else $error("undervoltage latch set with option removed"); // RL4
  a_ov_lower_high: assert property (s_ov_trip |=> lower_gate_drive && !upper_gate_drive)
                     else $error("overvoltage gate response wrong"); // RL5
  a_ov_lower_rel:  assert property (ov_latch_q ##0 s_drop_half ##1 s_drop_half
                     |=> !lower_gate_drive)
                     else $error("lower gate not released below half"); // RL5
  a_ov_latch_keep: assert property ($rose(ov_latch_q) |=> ov_latch_q [*8])
                     else $error("overvoltage latch cleared"); // RL6
  a_ov_arm_early:  assert property (sb.ov_prot && !soft_start_done |=> ov_latch_q)
                     else $error("overvoltage not armed during soft-start"); // RL7
  a_oc_blocks_uv:  assert property (oc_block_q && !uv_latch_q |=> !uv_latch_q)
                     else $error("undervoltage latched after overcurrent"); // RL8
  a_pg_window:     assert property (pg_q |-> !$past(sb.pg_uv) && !$past(sb.pg_ov))
                     else $error("power-good outside window"); // RL9
  a_pg_softstart:  assert property (!soft_start_done |=> !pg_q)
                     else $error("power-good during soft-start"); // RL10
  a_pg_oc_low:     assert property (sb.oc_trip |=> !pg_q ##1 power_good_oe)
                     else $error("overcurrent did not drop power-good"); // RL12
  a_pg_open_drain: assert property (!power_good_output && (power_good_oe == !pg_q))
                     else $error("power-good pin driven high or enable mismatched"); // RL18
  a_retry_after:   assert property (soft_start_restart |-> $past(oc_off_q, 1))
                     else $error("restart without overcurrent off"); // RL15

endmodule

//--- pkg/fault_mon_pkg.sv
// Constants shared by the buck fault monitor and its helpers.
// Assumes a single 25 MHz register clock.
package fault_mon_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_HZ        = 25_000_000;
  localparam int CLK_MHZ       = 25;
  localparam int FSW_SLOW_HZ   = 300_000;
  localparam int FSW_FAST_HZ   = 600_000;
  localparam int PERIOD_SLOW   = CLK_HZ / FSW_SLOW_HZ;
  localparam int PERIOD_FAST   = CLK_HZ / FSW_FAST_HZ;
  localparam int DMAX_SLOW_PCT = 85;
  localparam int DMAX_FAST_PCT = 75;
  localparam int HICCUP_US     = 10_000;
  localparam int HICCUP_CYC    = HICCUP_US * CLK_MHZ;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_DUTY     = 12'h004;
  localparam logic [11:0] OFF_STATUS   = 12'h008;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h00c;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h010;
  localparam logic        CTRL_RST     = 1'b1;
  localparam logic [7:0]  DUTY_RST     = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int IRQ_UV    = 0;
  localparam int IRQ_OV    = 1;
  localparam int IRQ_OC    = 2;
  localparam int IRQ_PGF   = 3;
  localparam int IRQ_RETRY = 4;
  localparam int IRQ_W     = 5;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

  localparam int SI_UV   = 0;
  localparam int SI_OV   = 1;
  localparam int SI_HALF = 2;
  localparam int SI_PGU  = 3;
  localparam int SI_PGO  = 4;
  localparam int SI_OC   = 5;
  localparam int SI_EN   = 6;
  localparam int N_SYNC  = 7;

endpackage

//--- pkg/sync_bus_if.sv
// Synchronised comparator and enable levels between the input stage and the monitor.
// Assumes both ends run on pclk.
interface sync_bus_if;
  logic uv_prot;
  logic ov_prot;
  logic below_half;
  logic pg_uv;
  logic pg_ov;
  logic oc_trip;
  logic enable;
  modport src (output uv_prot, ov_prot, below_half, pg_uv, pg_ov, oc_trip, enable);
  modport dst (input  uv_prot, ov_prot, below_half, pg_uv, pg_ov, oc_trip, enable);
endinterface

//--- design/input_sync.sv
// Three-flop synchronisers for asynchronous comparator and pin inputs.
// Assumes raw inputs may change at any time relative to pclk.
module input_sync
  import fault_mon_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic [N_SYNC-1:0] raw,
  sync_bus_if.src                sb
);
  logic [N_SYNC-1:0] out_q;

  // ****************************************
  // Per-bit chain; a change counts once stages two and three agree
  // ****************************************
  for (genvar i = 0; i < N_SYNC; i++) begin : g_bit
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_q     <= 1'b0;
        s2_q     <= 1'b0;
        s3_q     <= 1'b0;
        out_q[i] <= 1'b0;
      end else if (ce) begin
        s1_q <= raw[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          out_q[i] <= s3_q;
        end
      end
    end
  end

  assign sb.uv_prot    = out_q[SI_UV];
  assign sb.ov_prot    = out_q[SI_OV];
  assign sb.below_half = out_q[SI_HALF];
  assign sb.pg_uv      = out_q[SI_PGU];
  assign sb.pg_ov      = out_q[SI_PGO];
  assign sb.oc_trip    = out_q[SI_OC];
  assign sb.enable     = out_q[SI_EN];
endmodule

//--- design/duty_limiter.sv
// Fixed-frequency PWM with a hard cap on upper-gate on-time.
// Assumes duty is given in pclk cycles per switching period.
module duty_limiter #(
  parameter int PERIOD = 83,
  parameter int MAX_ON = 70
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [7:0] duty,
  output logic            pwm_on
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] cap;
  logic       wrap;

  localparam logic [7:0] LAST = 8'(PERIOD - 1);
  localparam logic [7:0] MAXC = 8'(MAX_ON);

  assign wrap  = (cnt_q == LAST);
  assign cnt_d = wrap ? 8'h00 : 8'(cnt_q + 8'h01);
  assign cap   = (duty > MAXC) ? MAXC : duty;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 8'h00;
      pwm_on <= 1'b0;
    end else if (ce) begin
      cnt_q  <= run ? cnt_d : 8'h00;
      pwm_on <= run && (cnt_q < cap); // RL16 RL17
    end
  end
endmodule

//--- bench/buck_plant_model.sv
// Behavioural model of the output comparators that face the monitor.
// Assumes the bench sets one voltage level code; comparators follow it at once.
module buck_plant_model (
  input  wire logic [2:0] lvl,
  output logic            uv_prot_raw,
  output logic            ov_prot_raw,
  output logic            below_half_raw,
  output logic            pg_uv_raw,
  output logic            pg_ov_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Level ladder
  // ****************************************
  // 0 below half, 1 below protection low, 2 below window, 3 in window,
  // 4 above window, 5 above protection high
  assign below_half_raw = (lvl == 3'h0);
  assign uv_prot_raw    = (lvl <= 3'h1);
  assign pg_uv_raw      = (lvl <= 3'h2);
  assign pg_ov_raw      = (lvl >= 3'h4);
  assign ov_prot_raw    = (lvl == 3'h5);
endmodule

//--- bench/buck_fault_protection_monitor_test.sv
// Self-checking bench for the buck fault monitor.
// Assumes the package constants and the plant model; one 25 MHz clock.
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module buck_fault_protection_monitor_test
  import fault_mon_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HIC_T = 20;
  logic        pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, ugd, lgd, pgo, pgoe, ssr, irq, er;
  logic        ugd2, lgd2, pgoe2, ssr2;
  logic        oc = 1'b0, en = 1'b1, ssd = 1'b0;
  logic [2:0]  lvl = 3'h3;
  wire logic   uvr, ovr, bhr, pgur, pgor;
  int          err_total = 0, n_tests = 0, cnt, d, i;
  always #20 pclk = ~pclk;
  buck_plant_model plant (.lvl(lvl), .uv_prot_raw(uvr), .ov_prot_raw(ovr),
    .below_half_raw(bhr), .pg_uv_raw(pgur), .pg_ov_raw(pgor));
  buck_fault_monitor #(.HICCUP_CYCLES(HIC_T)) DUT (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .uv_prot_raw(uvr), .ov_prot_raw(ovr), .below_half_raw(bhr), .pg_uv_raw(pgur),
    .pg_ov_raw(pgor), .overcurrent_trip_raw(oc), .enable_raw(en),
    .soft_start_done(ssd), .upper_gate_drive(ugd), .lower_gate_drive(lgd),
    .power_good_output(pgo), .power_good_oe(pgoe), .soft_start_restart(ssr), .irq(irq));
  // Fast hiccup variant without undervoltage latch, on the same pins and bus
  buck_fault_monitor #(.UV_PROT_EN(1'b0), .HICCUP_MODE(1'b1), .FAST_VARIANT(1'b1),
    .HICCUP_CYCLES(HIC_T)) dut_alt (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .uv_prot_raw(uvr), .ov_prot_raw(ovr), .below_half_raw(bhr), .pg_uv_raw(pgur),
    .pg_ov_raw(pgor), .overcurrent_trip_raw(oc), .enable_raw(en),
    .soft_start_done(ssd), .upper_gate_drive(ugd2), .lower_gate_drive(lgd2),
    .power_good_output(), .power_good_oe(pgoe2), .soft_start_restart(ssr2), .irq());
  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k == 20) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic settle();
    repeat (8) @(posedge pclk);
  endtask
  task automatic por();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task automatic toggle_en();
    en <= 1'b0; settle(); en <= 1'b1; settle();
  endtask
  function automatic int duty_cap(input int v, input int p, input int pct);
    int m;
    m = p * pct / 100;
    return (v > m) ? m : v;
  endfunction
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    d = $urandom(32'h47361f9c);
    repeat (3) @(posedge pclk);
    `CHK("pg_oe_rst", 1'b1, pgoe)
    por();
    apb(1'b0, OFF_CTRL, 32'h0);
    `CHK("ctrl", 32'h1, q)
    for (i = 0; i < 4; i++) begin
      d = $urandom;
      apb(1'b1, OFF_IRQ_MASK, d);
      apb(1'b0, OFF_IRQ_MASK, 32'h0);
      `CHK("mask", {27'h0, d[4:0]}, q)
    end
    apb(1'b0, 12'hffc, 32'h0);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, OFF_IRQ_MASK, 32'h1);
    lvl <= 3'h1; settle();
    `CHK("pg_oe_ss", 1'b1, pgoe)
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("uv_ss", 1'b0, q[0])
    lvl <= 3'h3; settle();
    ssd <= 1'b1; settle();
    `CHK("pg_oe_win", 1'b0, pgoe)
    `CHK("pg_data", 1'b0, pgo)
    ssd <= 1'b0; settle(); ssd <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("pg_rise", 1'b0, pgoe)
    lvl <= 3'h4; settle();
    `CHK("pg_ov_win", 1'b1, pgoe)
    lvl <= 3'h3; oc <= 1'b1; settle();
    `CHK("pg_oc", 1'b1, pgoe)
    lvl <= 3'h1; settle();
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("uv_oc_block", 1'b0, q[0])
    oc <= 1'b0; lvl <= 3'h3; toggle_en();
    `CHK("pg_oc_clr", 1'b0, pgoe)
    lvl <= 3'h1; settle();
    `CHK("ug_uv", 1'b0, ugd)
    `CHK("lg_uv", 1'b0, lgd)
    `CHK("uv_opt_lg", 1'b1, lgd2)
    `CHK("uv_opt_pg", 1'b1, pgoe2)
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("uv_latch", 1'b1, q[0])
    `CHK("irq_set", 1'b1, irq)
    apb(1'b1, OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq_clr", 1'b0, irq)
    lvl <= 3'h3; settle();
    `CHK("pg_no_latch", 1'b0, pgoe)
    toggle_en();
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("uv_hold", 1'b1, q[0])
    ssd <= 1'b0; por(); settle();
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("uv_por", 1'b0, q[0])
    lvl <= 3'h5; settle();
    `CHK("ug_ov", 1'b0, ugd)
    `CHK("lg_ov", 1'b1, lgd)
    lvl <= 3'h0; settle();
    `CHK("lg_half", 1'b0, lgd)
    lvl <= 3'h5; settle();
    `CHK("lg_again", 1'b1, lgd)
    lvl <= 3'h3; toggle_en();
    apb(1'b0, OFF_STATUS, 32'h0);
    `CHK("ov_hold", 1'b1, q[1])
    ssd <= 1'b1; por(); settle();
    for (i = 0; i < 2; i++) begin
      d = (i == 0) ? 255 : 1 + ($urandom % 60);
      apb(1'b1, OFF_DUTY, d);
      settle();
      cnt = 0;
      repeat (PERIOD_SLOW) begin
        @(posedge pclk);
        if (ugd === 1'b1) cnt++;
      end
      `CHK("on_cycles", duty_cap(d, PERIOD_SLOW, DMAX_SLOW_PCT), cnt)
      cnt = 0;
      repeat (PERIOD_FAST) begin
        @(posedge pclk);
        if (ugd2 === 1'b1) cnt++;
      end
      `CHK("on_fast", duty_cap(d, PERIOD_FAST, DMAX_FAST_PCT), cnt)
    end
    oc <= 1'b1;
    for (cnt = 1; cnt <= 60; cnt++) begin
      @(posedge pclk);
      if (ssr2 === 1'b1) break;
    end
    // Sync takes 4 edges, the off latch 1, the restart flop 1
    `CHK("hiccup_wait", HIC_T + 6, cnt)
    `CHK("no_retry", 1'b0, ssr)
    if (cnt > 60) finish_test();
    lvl <= 3'h5; settle();
    `CHK("lg_ov_oc", 1'b1, lgd)
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    finish_test();
  end
endmodule
